// ---- logic/crt_edge.sv ----
// Machine-cycle tick generator and pin edge sampler
`timescale 1ns/10ps
module crt_edge
  import crt_pkg::*;
(
  input  wire logic clk_i,       // Clock
  input  wire logic rst_n_i,     // Async reset, active low
  input  wire logic cnt_pin_i,   // Count input pin
  input  wire logic trg_pin_i,   // Trigger input pin
  crt_evt_if.src    evt          // Events out
);
  logic [3:0] div_cnt;
  logic [3:0] st_cnt;
  logic       cnt_q;
  logic       cnt_qq;
  logic       trg_q;
  logic       trg_qq;

  ////////////////////////////////////////////////////////////////////////
  // Tick dividers: machine cycle is twelve clocks, state time two
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 4'h0;
      st_cnt  <= 4'h0;
    end else begin
      div_cnt <= (div_cnt == CRT_TICK_DIV - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      st_cnt  <= (st_cnt == CRT_BAUD_DIV - 4'h1) ? 4'h0 : st_cnt + 4'h1;
    end
  end

  assign evt.tick       = (div_cnt == CRT_TICK_DIV - 4'h1);
  assign evt.state_tick = (st_cnt == CRT_BAUD_DIV - 4'h1);

  // Sample once per machine cycle, so narrow glitches are ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 1'b1;
      cnt_qq <= 1'b1;
      trg_q  <= 1'b1;
      trg_qq <= 1'b1;
    end else if (evt.tick) begin
      cnt_q  <= cnt_pin_i;
      cnt_qq <= cnt_q;
      trg_q  <= trg_pin_i;
      trg_qq <= trg_q;
    end
  end

  // High then low sample pair, one pulse per machine cycle
  assign evt.cnt_fall  = evt.tick & cnt_qq & ~cnt_q;
  assign evt.trg_fall  = evt.tick & trg_qq & ~trg_q;
  assign evt.trg_level = trg_q;
endmodule

// ---- logic/crt_evt_if.sv ----
// Interface carrying sampled pin events from edge detector to timer core
`timescale 1ns/10ps
interface crt_evt_if;
  logic cnt_fall;   // Count pin fell
  logic trg_fall;   // Trigger pin fell
  logic trg_level;  // Trigger pin sampled level
  logic tick;       // Machine-cycle tick
  logic state_tick; // State-time tick
  modport src (output cnt_fall, trg_fall, trg_level, tick, state_tick);
  modport dst (input  cnt_fall, trg_fall, trg_level, tick, state_tick);
endinterface

// ---- logic/crt_pkg.sv ----
// Package of constants, register map and types for the capture/reload timer
package crt_pkg;
  localparam int CRT_W = 16;
  localparam logic [7:0] CRT_ADDR_CTRL   = 8'hc8;
  localparam logic [7:0] CRT_ADDR_MODE   = 8'hc9;
  localparam logic [7:0] CRT_ADDR_CAPL   = 8'hca;
  localparam logic [7:0] CRT_ADDR_CAPH   = 8'hcb;
  localparam logic [7:0] CRT_ADDR_CNTL   = 8'hcc;
  localparam logic [7:0] CRT_ADDR_CNTH   = 8'hcd;
  localparam logic [7:0] CRT_ADDR_IEN    = 8'hd0;
  localparam int CRT_B_OVF  = 7;
  localparam int CRT_B_EXT  = 6;
  localparam int CRT_B_RCLK = 5;
  localparam int CRT_B_TX_CLOCK_SELECT = 4;
  localparam int CRT_B_EXEN = 3;
  localparam int CRT_B_RUN  = 2;
  localparam int CRT_B_SRC  = 1;
  localparam int CRT_B_CAP  = 0;
  localparam int CRT_B_DOWN_COUNT_ENABLE = 0;
  localparam int CRT_B_OE   = 1;
  localparam logic [7:0]  CRT_RST_BYTE  = 8'h00;
  localparam logic [15:0] CRT_ONES      = 16'hffff;
  localparam logic [15:0] CRT_ONE       = 16'h0001;
  localparam logic [3:0]  CRT_TICK_DIV  = 4'hc;
  localparam logic [3:0]  CRT_BAUD_DIV  = 4'h2;
  typedef enum logic [1:0] {
    CRT_OFF    = 2'b00,
    CRT_RELOAD = 2'b01,
    CRT_CAPT   = 2'b10,
    CRT_BAUD   = 2'b11
  } crt_mode_t;
endpackage

// ---- logic/crt_top.sv ----
// Capture/reload timer top: registers, modes, counting and flags
`timescale 1ns/10ps
module crt_top
  import crt_pkg::*;
#(
  parameter int W = CRT_W          // Counter width
)(
  input  wire logic       clk_i,     // Clock, 125 MHz
  input  wire logic       rst_n_i,   // Async reset, active low
  input  wire logic       cnt_pin_i, // Count input, port 1 bit 0
  input  wire logic       trg_pin_i, // Trigger input, port 1 bit 1
  input  wire logic [7:0] addr_i,    // Register address
  input  wire logic [7:0] wdata_i,   // Write data
  input  wire logic       wr_i,      // Write strobe
  input  wire logic       rd_i,      // Read strobe
  output logic      [7:0] rdata_o,   // Read data, one cycle later
  output logic            irq_o,     // Timer interrupt request
  output logic            ovf_pulse_o // Overflow pulse for serial clock
);
  crt_evt_if evt ();

  logic [W-1:0] count;
  logic [W-1:0] cap;
  logic         ovf_flag;
  logic         ext_flag;
  logic         rclk_sel;
  logic         tx_clock_select_sel;
  logic         exen;
  logic         run;
  logic         src_sel;
  logic         cap_sel;
  logic         down_count_enable;
  logic         oe_bit;
  logic         ien;
  crt_mode_t    mode;
  logic         step;
  logic         up_dir;
  logic         roll_up;
  logic         roll_dn;
  logic         trig_evt;
  logic         do_reload;
  logic         do_capture;
  logic [W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and ticks; count on bit 0, trigger on bit 1
  crt_edge u_edge (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .cnt_pin_i (cnt_pin_i),
    .trg_pin_i (trg_pin_i),
    .evt       (evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode, used by the write paths; the read path decodes with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Mode from clock selects, capture bit and run
  always_comb begin
    if (!run) begin
      mode = CRT_OFF;
    end else if (rclk_sel | tx_clock_select_sel) begin
      mode = CRT_BAUD;
    end else if (cap_sel) begin
      mode = CRT_CAPT;
    end else begin
      mode = CRT_RELOAD;
    end
  end

  // Count step: tick or count pin edge; baud mode without the pin source runs at state time
  always_comb begin
    case (mode)
      CRT_OFF:  step = 1'b0;
      CRT_BAUD: step = src_sel ? evt.cnt_fall : evt.state_tick;
      default:  step = src_sel ? evt.cnt_fall : evt.tick;
    endcase
  end

  // Direction: only up/down reload mode may count down
  assign up_dir   = !(down_count_enable && (mode == CRT_RELOAD)) || evt.trg_level;
  assign roll_up  = step && up_dir && (count == CRT_ONES[W-1:0]);
  assign roll_dn  = step && !up_dir && (count == cap);
  assign trig_evt = exen && evt.trg_fall && (mode != CRT_OFF);
  assign do_capture = trig_evt && (mode == CRT_CAPT);
  // Trigger reload only in up-only reload mode
  assign do_reload  = (mode == CRT_RELOAD) &&
                      (roll_up || (trig_evt && !down_count_enable));

  // Next count value
  always_comb begin
    next_count = count;
    if (roll_dn) begin
      next_count = CRT_ONES[W-1:0];
    end else if (do_reload || (mode == CRT_BAUD && roll_up)) begin
      next_count = cap;
    end else if (step && up_dir) begin
      next_count = count + CRT_ONE[W-1:0];
    end else if (step) begin
      next_count = count - CRT_ONE[W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter; a software write wins over counting for the written byte, the other byte takes the counted value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CNTL)) begin
      count <= {next_count[W-1:8], wdata_i};
    end else if (wr_i && hit(addr_i, CRT_ADDR_CNTH)) begin
      count <= {wdata_i, next_count[7:0]};
    end else begin
      count <= next_count;
    end
  end

  // Capture/reload register; capture wins over a software write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap <= '0;
    end else if (do_capture) begin
      cap <= count;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CAPL)) begin
      cap[7:0] <= wdata_i;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CAPH)) begin
      cap[W-1:8] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits; software alone clears the overflow flag, rollovers also toggle ext_flag in up/down mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rclk_sel <= 1'b0;
      tx_clock_select_sel <= 1'b0;
      exen     <= 1'b0;
      run      <= 1'b0;
      src_sel  <= 1'b0;
      cap_sel  <= 1'b0;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CTRL)) begin
      rclk_sel <= wdata_i[CRT_B_RCLK];
      tx_clock_select_sel <= wdata_i[CRT_B_TX_CLOCK_SELECT];
      exen     <= wdata_i[CRT_B_EXEN];
      run      <= wdata_i[CRT_B_RUN];
      src_sel  <= wdata_i[CRT_B_SRC];
      cap_sel  <= wdata_i[CRT_B_CAP];
    end
  end

  // Overflow flag: hardware set beats a software clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_flag <= 1'b0;
    end else if ((roll_up || roll_dn) && mode != CRT_BAUD) begin
      ovf_flag <= 1'b1;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CTRL)) begin
      ovf_flag <= wdata_i[CRT_B_OVF];
    end
  end

  // External flag: set on trigger, or toggled as 17th bit up/down
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_flag <= 1'b0;
    end else if (mode == CRT_RELOAD && down_count_enable) begin
      if (roll_up || roll_dn) begin
        ext_flag <= ~ext_flag;
      end else if (wr_i && hit(addr_i, CRT_ADDR_CTRL)) begin
        ext_flag <= wdata_i[CRT_B_EXT];
      end
    end else if (trig_evt) begin
      ext_flag <= 1'b1;
    end else if (wr_i && hit(addr_i, CRT_ADDR_CTRL)) begin
      ext_flag <= wdata_i[CRT_B_EXT];
    end
  end

  // Mode register and interrupt enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      down_count_enable   <= 1'b0;
      oe_bit <= 1'b0;
      ien    <= 1'b0;
    end else if (wr_i && hit(addr_i, CRT_ADDR_MODE)) begin
      down_count_enable   <= wdata_i[CRT_B_DOWN_COUNT_ENABLE];
      oe_bit <= wdata_i[CRT_B_OE];
    end else if (wr_i && hit(addr_i, CRT_ADDR_IEN)) begin
      ien    <= wdata_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt: external flag is a count bit in up/down mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ien && (ovf_flag ||
               (ext_flag && !down_count_enable));
    end
  end

  // Baud overflow pulse, registered so output is a clean flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_pulse_o <= 1'b0;
    end else begin
      ovf_pulse_o <= (mode == CRT_BAUD) && roll_up;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= CRT_RST_BYTE;
    end else if (!rd_i) begin
      rdata_o <= CRT_RST_BYTE;
    end else begin
      case (addr_i)
        CRT_ADDR_CTRL: rdata_o <= {ovf_flag, ext_flag, rclk_sel, tx_clock_select_sel,
                                   exen, run, src_sel, cap_sel};
        CRT_ADDR_MODE: rdata_o <= {6'h00, oe_bit, down_count_enable};
        CRT_ADDR_CAPL: rdata_o <= cap[7:0];
        CRT_ADDR_CAPH: rdata_o <= cap[W-1:8];
        CRT_ADDR_CNTL: rdata_o <= count[7:0];
        CRT_ADDR_CNTH: rdata_o <= count[W-1:8];
        CRT_ADDR_IEN:  rdata_o <= {7'h00, ien};
        default:       rdata_o <= CRT_RST_BYTE;
      endcase
    end
  end
endmodule

// ---- tb/crt_pin_src.sv ----
// Model of the external count and trigger sources
`timescale 1ns/10ps
module crt_pin_src (
  input  wire logic clk_i, // Clock
  output logic      cnt_o, // Count pin
  output logic      trg_o  // Trigger pin
);
  ////////////////////////////////////////////////////////////////////////
  // Idle high, as the port pull-ups leave them
  initial begin
    cnt_o = 1'b1;
    trg_o = 1'b1;
  end
  // Each level held two ticks so no sample can miss it
  task automatic cnt_falls(input int n);
    repeat (n) begin
      cnt_o <= 1'b0;
      repeat (24) @(posedge clk_i);
      cnt_o <= 1'b1;
      repeat (24) @(posedge clk_i);
    end
  endtask
  task automatic set_trg(input logic v);
    trg_o <= v;
    repeat (24) @(posedge clk_i);
  endtask
endmodule

// ---- tb/crt_top_monitor.sv ----
// Port checker for the capture/reload timer, bound to its top
`timescale 1ns/10ps
module crt_top_monitor
  import crt_pkg::*;
(
  input wire logic       clk_i,      // Clock
  input wire logic       rst_n_i,    // Reset, active low
  input wire logic       cnt_pin_i,  // Count pin
  input wire logic       trg_pin_i,  // Trigger pin
  input wire logic [7:0] addr_i,     // Address
  input wire logic [7:0] wdata_i,    // Write data
  input wire logic       wr_i,       // Write strobe
  input wire logic       rd_i,       // Read strobe
  input wire logic [7:0] rdata_o,    // Read data
  input wire logic       irq_o,      // Interrupt
  input wire logic       ovf_pulse_o // Baud pulse
);
  logic [5:0] ctrl_q;  // Software-only control bits
  logic       ien_q;   // Interrupt enable copy
  logic       baud_on; // Running in baud mode
  ////////////////////////////////////////////////////////////////////////
  // Copies track writes only; flags left out, hardware sets them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 6'h00;
      ien_q  <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == CRT_ADDR_CTRL) ctrl_q <= wdata_i[5:0];
      if (addr_i == CRT_ADDR_IEN) ien_q <= wdata_i[0];
    end
  end
  assign baud_on = ctrl_q[2] && (ctrl_q[5:4] != 2'b00);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_ctrl_read: assert property (rd_i && addr_i == CRT_ADDR_CTRL
    |=> rdata_o[5:0] == $past(ctrl_q)) else $error("control readback");
  a_mode_read: assert property (rd_i && addr_i == CRT_ADDR_MODE
    |=> rdata_o[7:2] == 6'h00) else $error("mode spare bits set");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h00
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_pulse_single: assert property (ovf_pulse_o |=> !ovf_pulse_o)
    else $error("baud pulse too long");
  a_pulse_baud: assert property (ovf_pulse_o |-> $past(baud_on))
    else $error("baud pulse outside baud mode");
  a_irq_enable: assert property (irq_o |-> $past(ien_q))
    else $error("interrupt while disabled");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i, 2))
    else $error("interrupt dropped without a write");
endmodule
bind crt_top crt_top_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cnt_pin_i(cnt_pin_i), .trg_pin_i(trg_pin_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .ovf_pulse_o(ovf_pulse_o));

// ---- tb/crt_top_tb_top.sv ----
// Self-checking bench for the capture/reload timer
`timescale 1ns/10ps
module crt_top_tb_top;
  import crt_pkg::*;
  logic       clk_i   = 1'b0; // Clock
  logic       rst_n_i;        // Reset
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       ovf_pulse_o;
  logic       cnt_pin_i;
  logic       trg_pin_i;
  int         bad_count = 0;
  int         compares  = 0;
  int         pulses    = 0;
  int         pulse_base;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (ovf_pulse_o === 1'b1) pulses <= pulses + 1;
  crt_pin_src i_src (.clk_i(clk_i), .cnt_o(cnt_pin_i), .trg_o(trg_pin_i));
  crt_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cnt_pin_i(cnt_pin_i),
    .trg_pin_i(trg_pin_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .ovf_pulse_o(ovf_pulse_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Strobes drop one edge after rising, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic irq_is(input logic e);
    #1;
    chk({7'h00, irq_o}, {7'h00, e});
    @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog well past the several hundred cycles the tests need
  initial begin
    nap(20000);
    bad_count++;
    summarize();
  end
  initial begin
    // Bus idle and reset asserted before the first edge
    rst_n_i <= 1'b0;
    addr_i  <= 8'h00;
    wdata_i <= 8'h00;
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    nap(2);
    rst_n_i <= 1'b1;
    nap(1);
    for (int a = 8'hc8; a <= 8'hcd; a++) rd(a[7:0], 8'h00);
    rd(8'h00, 8'h00);
    // Stopped timer keeps its count
    wr(CRT_ADDR_CNTL, 8'h34);
    nap(40);
    rd(CRT_ADDR_CNTL, 8'h34);
    // Up-only reload on overflow
    wr(CRT_ADDR_IEN, 8'h01);
    rd(CRT_ADDR_IEN, 8'h01);
    wr(CRT_ADDR_CAPH, 8'hab);
    wr(CRT_ADDR_CNTH, 8'hff);
    wr(CRT_ADDR_CNTL, 8'hfe);
    wr(CRT_ADDR_CTRL, 8'h04);
    nap(40);
    rd(CRT_ADDR_CTRL, 8'h84);
    rd(CRT_ADDR_CNTH, 8'hab);
    irq_is(1'b1);
    wr(CRT_ADDR_CTRL, 8'h00);
    irq_is(1'b0);
    // Capture mode: overflow without reload, then a capture
    wr(CRT_ADDR_CNTH, 8'hff);
    wr(CRT_ADDR_CNTL, 8'hfe);
    wr(CRT_ADDR_CTRL, 8'h0d);
    nap(30);
    i_src.set_trg(1'b0);
    rd(CRT_ADDR_CTRL, 8'hcd);
    rd(CRT_ADDR_CAPH, 8'h00);
    rd(CRT_ADDR_CNTH, 8'h00);
    i_src.set_trg(1'b1);
    // Trigger reload in up-only mode
    wr(CRT_ADDR_CTRL, 8'h00);
    wr(CRT_ADDR_CAPH, 8'h55);
    wr(CRT_ADDR_CTRL, 8'h0c);
    i_src.set_trg(1'b0);
    rd(CRT_ADDR_CNTH, 8'h55);
    rd(CRT_ADDR_CTRL, 8'h4c);
    i_src.set_trg(1'b1);
    // Event counting from the count pin
    wr(CRT_ADDR_CTRL, 8'h00);
    wr(CRT_ADDR_CNTL, 8'h00);
    wr(CRT_ADDR_CTRL, 8'h06);
    i_src.cnt_falls(3);
    rd(CRT_ADDR_CNTL, 8'h03);
    // Up/down: underflow at match, then overflow with reload
    wr(CRT_ADDR_CTRL, 8'h00);
    wr(CRT_ADDR_MODE, 8'h03);
    rd(CRT_ADDR_MODE, 8'h03);
    wr(CRT_ADDR_CAPH, 8'h00);
    wr(CRT_ADDR_CAPL, 8'h10);
    wr(CRT_ADDR_CNTH, 8'h00);
    wr(CRT_ADDR_CNTL, 8'h12);
    i_src.set_trg(1'b0);
    wr(CRT_ADDR_CTRL, 8'h04);
    nap(48);
    rd(CRT_ADDR_CNTH, 8'hff);
    rd(CRT_ADDR_CTRL, 8'hc4);
    wr(CRT_ADDR_CTRL, 8'h44);
    irq_is(1'b0);
    i_src.set_trg(1'b1);
    wr(CRT_ADDR_CNTL, 8'hfe);
    nap(40);
    rd(CRT_ADDR_CNTH, 8'h00);
    rd(CRT_ADDR_CTRL, 8'h84);
    wr(CRT_ADDR_MODE, 8'h00);
    // Baud mode: pulses every four state times, no flag
    wr(CRT_ADDR_CTRL, 8'h00);
    wr(CRT_ADDR_CAPH, 8'hff);
    wr(CRT_ADDR_CAPL, 8'hfc);
    // Start near the top, else the first rollover is far away
    wr(CRT_ADDR_CNTH, 8'hff);
    wr(CRT_ADDR_CNTL, 8'hfc);
    wr(CRT_ADDR_CTRL, 8'h14);
    pulse_base = pulses;
    nap(80);
    rd(CRT_ADDR_CTRL, 8'h14);
    chk({7'h00, (pulses - pulse_base) inside {[8:11]}}, 8'h01);
    summarize();
  end
endmodule
